/* rtl/mtd_pkg.sv */
// Constants, register map and state type for the transmit descriptor engine.
// Assumes a 32-bit APB register bus and a 32-bit memory port taking word-aligned byte addresses.
package mtd_pkg;

    localparam int MTD_NUM_CH = 8;

    // Register byte offsets
    localparam logic [11:0] MTD_TX_HEAD_BASE = 12'h000;
    localparam logic [11:0] MTD_TX_CP_BASE = 12'h040;
    localparam logic [11:0] MTD_RX_CP_BASE = 12'h080;
    localparam logic [11:0] MTD_TX_UNMASKED = 12'h0c0;
    localparam logic [11:0] MTD_TX_EN_SET = 12'h0c4;
    localparam logic [11:0] MTD_TX_EN_CLR = 12'h0c8;
    localparam logic [11:0] MTD_RX_UNMASKED = 12'h0d0;
    localparam logic [11:0] MTD_RX_EN_SET = 12'h0d4;
    localparam logic [11:0] MTD_RX_EN_CLR = 12'h0d8;
    localparam logic [11:0] MTD_GLOBAL_CTRL = 12'h0e0;
    localparam logic [11:0] MTD_TX_ABORT = 12'h0e4;

    // Descriptor word byte offsets
    localparam logic [31:0] MTD_W_LINK = 32'h0000_0000;
    localparam logic [31:0] MTD_W_BUF = 32'h0000_0004;
    localparam logic [31:0] MTD_W_OFFLEN = 32'h0000_0008;
    localparam logic [31:0] MTD_W_FLAGS = 32'h0000_000c;

    // Flag positions in the flags-and-length word
    localparam int MTD_F_FIRST = 31;
    localparam int MTD_F_LAST = 30;
    localparam int MTD_F_HELD = 29;
    localparam int MTD_F_HALTED = 28;
    localparam int MTD_F_ABORT = 27;
    localparam int MTD_F_SWFCS = 26;

    localparam int MTD_GLOBAL_EN_BIT = 0;

    // Reset values
    localparam logic [31:0] MTD_PTR_RST = 32'h0000_0000;
    localparam logic [7:0] MTD_EN_RST = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_BUF,
        ST_RD_OFFLEN,
        ST_RD_FLAGS,
        ST_DATA_RD,
        ST_DATA_OUT,
        ST_RD_LINK,
        ST_WR_HALT,
        ST_WR_HELD,
        ST_WR_ABORT
    } mtd_state_t;

endpackage

/* rtl/mtd_tx_dma.sv */
// Transmit descriptor engine with per-channel completion pointers and interrupt.
// Assumes an APB master, a memory port answering with mem_ack_i on the same clock,
// and a receive engine reporting finished descriptors on rx_done_* from this clock.
//
// Notes on behaviour
// - Eight transmit and eight receive completion pointer registers, also acknowledging.
// - Reading a completion pointer returns the last descriptor the engine finished.
// - Written value is software's last; interrupt active while it differs.
// - Writing the engine's own pointer value clears that channel's interrupt.
// - Channel interrupt forwarded only when enabled through the enable-set register.
// - Unmasked status registers show every channel's interrupt state regardless of mask.
// - Combined interrupt needs the global enable as well as channel enables.
// - Descriptor is four consecutive word-aligned 32-bit words.
// - Words: link, buffer pointer, offset/length, flags/packet length.
// - First fragment bit 31, last bit 30, held-by-engine bit 29.
// - Zero link ends the queue; pointers and lengths never modified.
// - Link re-read late; zero link after a last fragment halts channel and marks halted bit 28.
// - Buffer pointer any byte address; link pointer word aligned.
// - Skip buffer-offset leading bytes before data; zero means first byte.
// - Offset applied only on the first-fragment descriptor.
// - Buffer length counts valid bytes, excluding offset bytes.
// - Packet length read only from the first-fragment descriptor.
// - First and last fragment flags are left unchanged by the engine.
// - Held flag used only on first fragment, cleared when packet finished.
// - Software starts an idle channel by writing its queue head pointer.
// - Halted flag set on last-fragment descriptor whose link is zero.
// - Abort marks first unsent packet's first descriptor and stops the channel.
// - Software FCS flag passes supplied frame check bytes, no own CRC.
`timescale 1ns/1ps
module mtd_tx_dma
    import mtd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_first_o,
    output logic tx_last_o,
    output logic tx_software_fcs_o,
    input wire logic tx_ready_i,
    input wire logic rx_done_valid_i,
    input wire logic [2:0] rx_done_chan_i,
    input wire logic [31:0] rx_done_ptr_i,
    output logic irq_o
);

    mtd_state_t state_q;
    logic [2:0] ch_q;
    logic [31:0] cur_q;
    logic [31:0] buf_q;
    logic [15:0] off_q;
    logic [15:0] blen_q;
    logic [31:0] flags_q;
    logic [31:0] first_addr_q;
    logic [31:0] first_flags_q;
    logic [31:0] link_q;
    logic [31:0] ptr_q;
    logic [15:0] rem_q;
    logic [15:0] pkt_rem_q;
    logic first_byte_q;
    logic halted_q;
    logic [7:0] byte_q;

    logic [31:0] tx_head_q [MTD_NUM_CH];
    logic [31:0] tx_done_q [MTD_NUM_CH];
    logic [31:0] tx_cp_q [MTD_NUM_CH];
    logic [31:0] rx_done_q [MTD_NUM_CH];
    logic [31:0] rx_cp_q [MTD_NUM_CH];
    logic [MTD_NUM_CH-1:0] abort_pend_q;
    logic [7:0] tx_en_q;
    logic [7:0] rx_en_q;
    logic global_en_q;

    logic [MTD_NUM_CH-1:0] tx_stat;
    logic [MTD_NUM_CH-1:0] rx_stat;

    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic mem_req_q;
    logic mem_we_q;
    logic [31:0] mem_addr_q;
    logic [31:0] mem_wdata_q;
    logic tx_valid_q;
    logic [7:0] tx_data_q;
    logic tx_first_q;
    logic tx_last_q;
    logic swfcs_q;
    logic irq_q;

    logic apb_wr;
    logic [2:0] reg_ch;
    logic [31:0] rd_data;
    logic addr_ok;
    logic mem_fire;
    logic tx_fire;
    logic mem_state;
    logic mem_we_d;
    logic [31:0] mem_addr_d;
    logic [31:0] mem_wdata_d;
    logic pick_valid;
    logic [2:0] pick_ch;

    assign apb_wr = psel_i & penable_i & pwrite_i & pready_q;
    assign reg_ch = paddr_i[4:2];
    assign mem_fire = mem_req_q & mem_ack_i;
    assign tx_fire = tx_valid_q & tx_ready_i;

    // Channel interrupt state: engine pointer against software pointer
    genvar g;
    generate
        for (g = 0; g < MTD_NUM_CH; g++) begin : g_stat
            assign tx_stat[g] = tx_done_q[g] != tx_cp_q[g];
            assign rx_stat[g] = rx_done_q[g] != rx_cp_q[g];
        end
    endgenerate

    // Register read decode
    always_comb begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        if (paddr_i[1:0] != 2'b00) begin
            addr_ok = 1'b0;
        end else if (paddr_i[11:5] == MTD_TX_HEAD_BASE[11:5]) begin
            rd_data = tx_head_q[reg_ch];
        end else if (paddr_i[11:5] == MTD_TX_CP_BASE[11:5]) begin
            rd_data = tx_done_q[reg_ch];
        end else if (paddr_i[11:5] == MTD_RX_CP_BASE[11:5]) begin
            rd_data = rx_done_q[reg_ch];
        end else begin
            case (paddr_i)
                MTD_TX_UNMASKED: rd_data = {24'h00_0000, tx_stat};
                MTD_RX_UNMASKED: rd_data = {24'h00_0000, rx_stat};
                MTD_TX_EN_SET, MTD_TX_EN_CLR: rd_data = {24'h00_0000, tx_en_q};
                MTD_RX_EN_SET, MTD_RX_EN_CLR: rd_data = {24'h00_0000, rx_en_q};
                MTD_GLOBAL_CTRL: rd_data = {31'h0000_0000, global_en_q};
                MTD_TX_ABORT: rd_data = {24'h00_0000, abort_pend_q};
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // One wait state on every access; data and error computed while address is held
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel_i & penable_i & ~pready_q;
            pslverr_q <= psel_i & penable_i & ~pready_q & ~addr_ok;
            prdata_q <= (psel_i & penable_i & ~pready_q & ~pwrite_i) ? rd_data : 32'h0000_0000;
        end
    end

    // Software-side pointers, enables and global enable
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < MTD_NUM_CH; i++) begin
                tx_cp_q[i] <= MTD_PTR_RST;
                rx_cp_q[i] <= MTD_PTR_RST;
            end
            tx_en_q <= MTD_EN_RST;
            rx_en_q <= MTD_EN_RST;
            global_en_q <= 1'b0;
        end else if (apb_wr && paddr_i[1:0] == 2'b00) begin
            if (paddr_i[11:5] == MTD_TX_CP_BASE[11:5]) begin
                tx_cp_q[reg_ch] <= pwdata_i;
            end
            if (paddr_i[11:5] == MTD_RX_CP_BASE[11:5]) begin
                rx_cp_q[reg_ch] <= pwdata_i;
            end
            case (paddr_i)
                MTD_TX_EN_SET: tx_en_q <= tx_en_q | pwdata_i[7:0];
                MTD_TX_EN_CLR: tx_en_q <= tx_en_q & ~pwdata_i[7:0];
                MTD_RX_EN_SET: rx_en_q <= rx_en_q | pwdata_i[7:0];
                MTD_RX_EN_CLR: rx_en_q <= rx_en_q & ~pwdata_i[7:0];
                MTD_GLOBAL_CTRL: global_en_q <= pwdata_i[MTD_GLOBAL_EN_BIT];
                default: ;
            endcase
        end
    end

    // Receive side completion, reported by the receive engine
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < MTD_NUM_CH; i++) begin
                rx_done_q[i] <= MTD_PTR_RST;
            end
        end else if (rx_done_valid_i) begin
            rx_done_q[rx_done_chan_i] <= rx_done_ptr_i;
        end
    end

    // Combined interrupt
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= global_en_q & (|(tx_stat & tx_en_q) | |(rx_stat & rx_en_q));
        end
    end

    // Lowest numbered channel with a live queue wins
    always_comb begin
        pick_valid = 1'b0;
        pick_ch = 3'd0;
        for (int i = MTD_NUM_CH - 1; i >= 0; i--) begin
            if (tx_head_q[i] != MTD_PTR_RST) begin
                pick_valid = 1'b1;
                pick_ch = 3'(i);
            end
        end
    end

    // Memory request for the current state
    always_comb begin
        mem_state = 1'b1;
        mem_we_d = 1'b0;
        mem_addr_d = 32'h0000_0000;
        mem_wdata_d = 32'h0000_0000;
        case (state_q)
            ST_RD_BUF: mem_addr_d = cur_q + MTD_W_BUF;
            ST_RD_OFFLEN: mem_addr_d = cur_q + MTD_W_OFFLEN;
            ST_RD_FLAGS: mem_addr_d = cur_q + MTD_W_FLAGS;
            ST_DATA_RD: mem_addr_d = {ptr_q[31:2], 2'b00};
            ST_RD_LINK: mem_addr_d = cur_q + MTD_W_LINK;
            ST_WR_HALT: begin
                mem_we_d = 1'b1;
                mem_addr_d = cur_q + MTD_W_FLAGS;
                mem_wdata_d = flags_q | (32'h1 << MTD_F_HALTED);
            end
            ST_WR_HELD: begin
                mem_we_d = 1'b1;
                mem_addr_d = first_addr_q + MTD_W_FLAGS;
                mem_wdata_d = first_flags_q & ~(32'h1 << MTD_F_HELD);
                if (halted_q && first_addr_q == cur_q) begin
                    mem_wdata_d[MTD_F_HALTED] = 1'b1;
                end
            end
            ST_WR_ABORT: begin
                mem_we_d = 1'b1;
                mem_addr_d = cur_q + MTD_W_FLAGS;
                mem_wdata_d = (flags_q | (32'h1 << MTD_F_ABORT)) & ~(32'h1 << MTD_F_HELD);
            end
            default: mem_state = 1'b0;
        endcase
    end

    // Request held until acknowledged, dropped for at least one cycle after
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_wdata_q <= 32'h0000_0000;
        end else begin
            mem_req_q <= mem_state & ~mem_fire;
            mem_we_q <= mem_we_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
        end
    end

    // Byte stream toward the transmitter
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_first_q <= 1'b0;
            tx_last_q <= 1'b0;
        end else begin
            tx_valid_q <= (state_q == ST_DATA_OUT) & ~tx_fire;
            tx_data_q <= byte_q;
            tx_first_q <= first_byte_q;
            tx_last_q <= pkt_rem_q == 16'h0001;
        end
    end

    // Descriptor walk; also owns queue heads, engine pointers and abort requests
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            ch_q <= 3'd0;
            cur_q <= MTD_PTR_RST;
            buf_q <= MTD_PTR_RST;
            off_q <= 16'h0000;
            blen_q <= 16'h0000;
            flags_q <= 32'h0000_0000;
            first_addr_q <= MTD_PTR_RST;
            first_flags_q <= 32'h0000_0000;
            link_q <= MTD_PTR_RST;
            ptr_q <= MTD_PTR_RST;
            rem_q <= 16'h0000;
            pkt_rem_q <= 16'h0000;
            first_byte_q <= 1'b0;
            halted_q <= 1'b0;
            byte_q <= 8'h00;
            swfcs_q <= 1'b0;
            abort_pend_q <= '0;
            for (int i = 0; i < MTD_NUM_CH; i++) begin
                tx_head_q[i] <= MTD_PTR_RST;
                tx_done_q[i] <= MTD_PTR_RST;
            end
        end else begin
            if (apb_wr && paddr_i[11:5] == MTD_TX_HEAD_BASE[11:5] && paddr_i[1:0] == 2'b00) begin
                tx_head_q[reg_ch] <= {pwdata_i[31:2], 2'b00};
            end
            case (state_q)
                ST_IDLE: begin
                    // An abort on a channel with nothing queued has nothing to mark
                    for (int i = 0; i < MTD_NUM_CH; i++) begin
                        if (tx_head_q[i] == MTD_PTR_RST) begin
                            abort_pend_q[i] <= 1'b0;
                        end
                    end
                    if (pick_valid) begin
                        ch_q <= pick_ch;
                        cur_q <= tx_head_q[pick_ch];
                        state_q <= ST_RD_BUF;
                    end
                end
                ST_RD_BUF: if (mem_fire) begin
                    buf_q <= mem_rdata_i;
                    state_q <= ST_RD_OFFLEN;
                end
                ST_RD_OFFLEN: if (mem_fire) begin
                    off_q <= mem_rdata_i[31:16];
                    blen_q <= mem_rdata_i[15:0];
                    state_q <= ST_RD_FLAGS;
                end
                ST_RD_FLAGS: if (mem_fire) begin
                    flags_q <= mem_rdata_i;
                    rem_q <= blen_q;
                    ptr_q <= buf_q;
                    state_q <= (blen_q == 16'h0000) ? ST_RD_LINK : ST_DATA_RD;
                    if (mem_rdata_i[MTD_F_FIRST]) begin
                        first_addr_q <= cur_q;
                        first_flags_q <= mem_rdata_i;
                        pkt_rem_q <= mem_rdata_i[15:0];
                        first_byte_q <= 1'b1;
                        swfcs_q <= mem_rdata_i[MTD_F_SWFCS];
                        ptr_q <= buf_q + {16'h0000, off_q};
                        if (abort_pend_q[ch_q]) begin
                            state_q <= ST_WR_ABORT;
                        end else if (!mem_rdata_i[MTD_F_HELD]) begin
                            // Not handed over yet: stop without touching memory
                            tx_head_q[ch_q] <= MTD_PTR_RST;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_DATA_RD: if (mem_fire) begin
                    byte_q <= 8'(mem_rdata_i >> {ptr_q[1:0], 3'b000});
                    state_q <= ST_DATA_OUT;
                end
                ST_DATA_OUT: if (tx_fire) begin
                    // One memory read per byte: simple, at the cost of bus bandwidth
                    ptr_q <= ptr_q + 32'h0000_0001;
                    rem_q <= rem_q - 16'h0001;
                    pkt_rem_q <= pkt_rem_q - 16'h0001;
                    first_byte_q <= 1'b0;
                    state_q <= (rem_q == 16'h0001) ? ST_RD_LINK : ST_DATA_RD;
                end
                ST_RD_LINK: if (mem_fire) begin
                    // Link read as late as possible so a late patch is still followed
                    link_q <= {mem_rdata_i[31:2], 2'b00};
                    if (flags_q[MTD_F_LAST]) begin
                        halted_q <= mem_rdata_i[31:2] == 30'h0000_0000;
                        if (mem_rdata_i[31:2] == 30'h0000_0000 && first_addr_q != cur_q) begin
                            state_q <= ST_WR_HALT;
                        end else begin
                            state_q <= ST_WR_HELD;
                        end
                    end else if (mem_rdata_i[31:2] == 30'h0000_0000) begin
                        tx_head_q[ch_q] <= MTD_PTR_RST;
                        state_q <= ST_IDLE;
                    end else begin
                        cur_q <= {mem_rdata_i[31:2], 2'b00};
                        tx_head_q[ch_q] <= {mem_rdata_i[31:2], 2'b00};
                        state_q <= ST_RD_BUF;
                    end
                end
                ST_WR_HALT: if (mem_fire) begin
                    state_q <= ST_WR_HELD;
                end
                ST_WR_HELD: if (mem_fire) begin
                    tx_done_q[ch_q] <= cur_q;
                    tx_head_q[ch_q] <= link_q;
                    state_q <= ST_IDLE;
                end
                ST_WR_ABORT: if (mem_fire) begin
                    tx_done_q[ch_q] <= cur_q;
                    tx_head_q[ch_q] <= MTD_PTR_RST;
                    abort_pend_q[ch_q] <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
            // Last: set wins over clear
            if (apb_wr && paddr_i == MTD_TX_ABORT) begin
                abort_pend_q[pwdata_i[2:0]] <= 1'b1;
            end
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign mem_req_o = mem_req_q;
    assign mem_we_o = mem_we_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign tx_valid_o = tx_valid_q;
    assign tx_data_o = tx_data_q;
    assign tx_first_o = tx_first_q;
    assign tx_last_o = tx_last_q;
    assign tx_software_fcs_o = swfcs_q;
    assign irq_o = irq_q;

endmodule

/* tb/mtd_tx_dma_assertions.sv */
// Port protocol checker for the transmit descriptor engine.
// Assumes it is bound onto mtd_tx_dma and sees only its ports.
`timescale 1ns/1ps
module mtd_tx_dma_assertions (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_first_o,
    input wire logic tx_last_o,
    input wire logic tx_ready_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    a_ready_wait:
        assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("ready not after one wait");
    a_ready_pulse:
        assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
    a_err_with_ready:
        assert property (pslverr_o |-> pready_o) else $error("error without ready");
    a_rdata_idle:
        assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");
    a_mem_hold:
        assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
            && $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("memory request changed early");
    a_mem_release:
        assert property (mem_req_o && mem_ack_i |=> !mem_req_o) else $error("memory request kept after ack");
    a_mem_aligned:
        assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0) else $error("memory address unaligned");
    a_byte_hold:
        assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_data_o, tx_first_o, tx_last_o}))
            else $error("byte dropped while stalled");
endmodule

bind mtd_tx_dma mtd_tx_dma_assertions i_mtd_tx_dma_assertions (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_first_o(tx_first_o),
    .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));

/* tb/mtd_mem_model.sv */
// Word memory holding descriptor lists and packet buffers.
// Assumes one request at a time; slow_i adds wait cycles.
`timescale 1ns/1ps
module mtd_mem_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic ack_o
);
    logic [31:0] m [0:255];
    logic [1:0] wait_q;
    // Unanswered bus shows garbage so an early sample cannot pass
    assign rdata_o = ack_o ? m[addr_i[9:2]] : ~m[addr_i[9:2]];
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_q <= 2'h0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= req_i && !ack_o && (!slow_i || wait_q == 2'h3);
            wait_q <= (req_i && !ack_o) ? wait_q + 2'h1 : 2'h0;
        end
    end
    always @(posedge clk_i) begin
        if (req_i && ack_o && we_i) begin
            m[addr_i[9:2]] <= wdata_i;
        end
    end
endmodule

/* tb/mac_tx_descriptor_dma_irq_tb_top.sv */
// Testbench: APB register tests and descriptor transfers through a memory model.
// Assumes buffer byte at address a holds a[7:0] xor 5a.
`timescale 1ns/1ps
module mac_tx_descriptor_dma_irq_tb_top;
    import mtd_pkg::*;
    logic clk, rst, psel, pen, pwr, pready, perr, mreq, mwe, mack, slow, tv, tf, tl, tfcs, trdy, rxv, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, maddr, mwd, mrd, rxp, r;
    logic [7:0] td;
    logic [2:0] rxc;
    logic [10:0] got[$], exp[$];
    int mismatches, n_compared;
    mtd_tx_dma i_mtd_tx_dma (.clk_sys_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr), .mem_req_o(mreq),
        .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mrd), .mem_ack_i(mack),
        .tx_valid_o(tv), .tx_data_o(td), .tx_first_o(tf), .tx_last_o(tl), .tx_software_fcs_o(tfcs),
        .tx_ready_i(trdy), .rx_done_valid_i(rxv), .rx_done_chan_i(rxc), .rx_done_ptr_i(rxp), .irq_o(irq));
    mtd_mem_model i_mtd_mem_model (.clk_i(clk), .reset_i(rst), .slow_i(slow), .req_i(mreq), .we_i(mwe),
        .addr_i(maddr), .wdata_i(mwd), .rdata_o(mrd), .ack_o(mack));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        trdy <= !rst && !trdy; // Ready low every other cycle
        if (tv && trdy) got.push_back({tfcs, tf, tl, td});
    end
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            end_of_test();
        end
        r = prd;
        e = perr;
        psel <= 0; pen <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 32'h0);
        chk(r, x);
    endtask
    task automatic wait_cp(input logic [11:0] a, input logic [31:0] x);
        for (int i = 0; i < 200 && r !== x; i++) apb(0, a, 32'h0);
        if (r !== x) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic irq_is(input logic x);
        repeat (3) @(negedge clk);
        chk({31'h0, irq}, {31'h0, x});
    endtask
    task automatic desc(input int a, input logic [31:0] l, b, ol, fl);
        i_mtd_mem_model.m[a / 4] = l;
        i_mtd_mem_model.m[a / 4 + 1] = b;
        i_mtd_mem_model.m[a / 4 + 2] = ol;
        i_mtd_mem_model.m[a / 4 + 3] = fl;
    endtask
    task automatic want(input logic [31:0] a, input int n, input logic f, input logic l, input logic s);
        for (int k = 0; k < n; k++) exp.push_back({s, f && k == 0, l && k == n - 1, 8'(a + k) ^ 8'h5a});
    endtask
    task automatic cmp_stream();
        chk(32'(got.size()), 32'(exp.size()));
        foreach (exp[i]) chk(32'(got[i]), 32'(exp[i]));
        got.delete();
        exp.delete();
    endtask
    function automatic logic [31:0] mw(input int a);
        return i_mtd_mem_model.m[a / 4];
    endfunction
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwd = 0; rxv = 0; rxc = 0; rxp = 0; slow = 0;
        for (int i = 0; i < 256; i++) i_mtd_mem_model.m[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)} ^ {4{8'h5a}};
        desc(32'h100, 32'h0, 32'h201, 32'h0002_0003, 32'he000_0003);
        desc(32'h140, 32'h160, 32'h211, 32'h0001_0002, 32'ha400_0004);
        desc(32'h160, 32'h0, 32'h230, 32'h0003_0002, 32'h4000_0000);
        repeat (4) @(posedge clk);
        rst <= 0;
        rd(MTD_TX_CP_BASE, 32'h0);
        rd(MTD_TX_EN_SET, 32'h0);
        rd(MTD_GLOBAL_CTRL, 32'h0);
        apb(0, 12'h0fc, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test reset and map done");
        want(32'h203, 3, 1, 1, 0);
        wr(MTD_TX_HEAD_BASE, 32'h100);
        wait_cp(MTD_TX_CP_BASE, 32'h100);
        cmp_stream();
        chk(mw(32'h10c), 32'hd000_0003);
        chk(mw(32'h100), 32'h0);
        chk(mw(32'h104), 32'h201);
        chk(mw(32'h108), 32'h0002_0003);
        rd(MTD_TX_UNMASKED, 32'h1);
        $display("test single fragment done");
        slow <= 1;
        want(32'h212, 2, 1, 0, 1);
        want(32'h230, 2, 0, 1, 1);
        wr(MTD_TX_HEAD_BASE | 12'h004, 32'h140);
        wait_cp(MTD_TX_CP_BASE | 12'h004, 32'h160);
        cmp_stream();
        chk(mw(32'h14c), 32'h8400_0004);
        chk(mw(32'h16c), 32'h5000_0000);
        rd(MTD_TX_UNMASKED, 32'h3);
        $display("test two fragments done");
        wr(MTD_TX_EN_SET, 32'h1);
        rd(MTD_TX_EN_SET, 32'h1);
        irq_is(0);
        wr(MTD_GLOBAL_CTRL, 32'h1);
        irq_is(1);
        wr(MTD_TX_CP_BASE, 32'h104);
        irq_is(1);
        wr(MTD_TX_CP_BASE, 32'h100);
        rd(MTD_TX_UNMASKED, 32'h2);
        irq_is(0);
        wr(MTD_TX_EN_SET, 32'h2);
        irq_is(1);
        wr(MTD_TX_EN_CLR, 32'h2);
        irq_is(0);
        $display("test transmit interrupt done");
        @(posedge clk);
        rxv <= 1; rxc <= 3'h2; rxp <= 32'h300;
        @(posedge clk);
        rxv <= 0;
        rd(MTD_RX_UNMASKED, 32'h4);
        rd(MTD_RX_CP_BASE | 12'h008, 32'h300);
        irq_is(0);
        wr(MTD_RX_EN_SET, 32'h4);
        irq_is(1);
        wr(MTD_RX_CP_BASE | 12'h008, 32'h300);
        rd(MTD_RX_UNMASKED, 32'h0);
        irq_is(0);
        $display("test receive interrupt done");
        end_of_test();
    end
endmodule
